// >>> src/fls_pkg.sv
/*
  Constants shared by the fill-level and event-status block: register
  addresses, field positions, reset values and buffer depths.
  Assumes the host interface decodes byte addresses 00h..7Fh.
*/
// Summary of operation
// - Host-writable 8-bit fill threshold register at address 03h.
// - 512-byte depth uses 9-bit threshold, msb from buffer control.
// - Near-empty flag is 1 while fill count is at or below threshold.
// - Near-full flag is 1 while depth minus fill count is at or below threshold.
// - Depth select 1 gives 255 bytes; depth select 0 gives 512 bytes.
// - Read-only fill count register at address 04h, reset value zero.
// - In 512-byte mode the fill count widens with extra msbs.
// - Count bits 9 and 8 are evaluated only in 512-byte mode.
// - Data port write at 05h pushes a byte; read pops one.
// - Fill count increments on data port write, decrements on read.
// - Data port accesses do not advance the auto-incrementing address.
// - Status write: bit 7 chooses set or clear for each written 1.
// - Writing FFh sets all seven status bits; 7Fh clears all but bits whose event fires in that cycle.
// - Near-full event latched in status bit 6 until host clears it.
// - Near-empty event latched in status bit 5 until host clears it.
package fls_pkg;
  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_THRESHOLD = 8'h03;
  localparam logic [7:0] ADDR_FILL_COUNT = 8'h04;
  localparam logic [7:0] ADDR_BUFFER_PORT = 8'h05;
  localparam logic [7:0] ADDR_EVENT_STATUS = 8'h06;

  // ---------------------------------------------------------------
  // Widths and depths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PTR_W = 9;
  localparam int COUNT_W = 10;
  localparam int THR_W = 9;
  localparam logic [9:0] DEPTH_SMALL = 10'h0ff;
  localparam logic [9:0] DEPTH_LARGE = 10'h200;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_SET_OP = 7;
  localparam int BIT_NEAR_FULL = 6;
  localparam int BIT_NEAR_EMPTY = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [9:0] FILL_COUNT_RESET = 10'h000;
  localparam logic [6:0] STATUS_RESET = 7'h00;
endpackage

// >>> src/fls_buffer_mem.sv
/*
  Byte storage for the host buffer: one write port, one read port.
  Assumes the caller keeps the occupancy count and never overruns.
*/
`timescale 1ns/1ps
`default_nettype none
module fls_buffer_mem #(
  parameter int DATA_W = 8,
  parameter int PTR_W = 9
) (
  // Clock
  input wire logic mclk,
  // Write side
  input wire logic wr_en,
  input wire logic [PTR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // Read side
  input wire logic [PTR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);
  // Asynchronous read lets the pop and the answer share one cycle
  logic [DATA_W-1:0] store [0:(1<<PTR_W)-1];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  assign rd_data = store[rd_addr];
endmodule // fls_buffer_mem
`default_nettype wire

// >>> src/fls_top.sv
/*
  Fill threshold, fill count, data port and first event-status register
  of the host byte buffer.
  Assumes a host interface that issues one-cycle read and write strobes
  with an address, and buffer control logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fls_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register access from the host interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic addr_hold,
  // Buffer control fields
  input wire logic depth_select,
  input wire logic threshold_msb,
  input wire logic flush,
  output logic [1:0] fill_count_msbs,
  output logic near_full_flag,
  output logic near_empty_flag,
  // Other event sources for status bits 4..0
  input wire logic [4:0] ext_events,
  output logic [6:0] event_status_0
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] threshold;
  logic [fls_pkg::COUNT_W-1:0] fill_cnt;
  logic [fls_pkg::PTR_W-1:0] wr_ptr;
  logic [fls_pkg::PTR_W-1:0] rd_ptr;
  logic [fls_pkg::DATA_W-1:0] mem_rd_data;
  logic [fls_pkg::COUNT_W-1:0] depth_eff;
  logic [fls_pkg::THR_W-1:0] thr_eff;
  logic [fls_pkg::COUNT_W-1:0] free_cnt;
  logic push;
  logic pop;
  logic wr_status;
  logic [6:0] sw_set;
  logic [6:0] sw_clr;
  logic [6:0] hw_set;
  logic [6:0] next_status;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // ---------------------------------------------------------------
  // Depth and threshold selection
  // ---------------------------------------------------------------
  assign depth_eff = depth_select ? fls_pkg::DEPTH_SMALL : fls_pkg::DEPTH_LARGE;
  // Extension bit ignored in the small mode
  assign thr_eff = depth_select ? {1'b0, threshold} : {threshold_msb, threshold};
  assign free_cnt = depth_eff - fill_cnt;

  // Writes to a full buffer and reads of an empty one are dropped
  assign push = reg_wr && hit(reg_addr, fls_pkg::ADDR_BUFFER_PORT) && (fill_cnt < depth_eff);
  assign pop = reg_rd && hit(reg_addr, fls_pkg::ADDR_BUFFER_PORT) && (fill_cnt != '0);

  // ---------------------------------------------------------------
  // Threshold register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      threshold <= fls_pkg::THRESHOLD_RESET;
    end else if (reg_wr && hit(reg_addr, fls_pkg::ADDR_THRESHOLD)) begin
      threshold <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Buffer pointers and fill count
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill_cnt <= fls_pkg::FILL_COUNT_RESET;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
        fill_cnt <= fill_cnt + 1'b1;
      end else if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
        fill_cnt <= fill_cnt - 1'b1;
      end
    end
  end

  // One store serves both depths; only the count limit differs
  fls_buffer_mem #(
    .DATA_W(fls_pkg::DATA_W),
    .PTR_W(fls_pkg::PTR_W)
  ) u_mem (
    .mclk(mclk),
    .wr_en(push),
    .wr_addr(wr_ptr),
    .wr_data(reg_wdata),
    .rd_addr(rd_ptr),
    .rd_data(mem_rd_data)
  );

  // ---------------------------------------------------------------
  // Live level flags and count extension
  // ---------------------------------------------------------------
  // Reset values match an empty buffer so no event fires out of reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      near_empty_flag <= 1'b1;
      near_full_flag <= 1'b0;
      fill_count_msbs <= 2'b00;
    end else begin
      near_empty_flag <= (fill_cnt <= {1'b0, thr_eff});
      near_full_flag <= (free_cnt <= {1'b0, thr_eff});
      fill_count_msbs <= depth_select ? 2'b00 : fill_cnt[9:8];
    end
  end

  // ---------------------------------------------------------------
  // Event status register
  // ---------------------------------------------------------------
  assign wr_status = reg_wr && hit(reg_addr, fls_pkg::ADDR_EVENT_STATUS);
  assign sw_set = (wr_status && reg_wdata[fls_pkg::BIT_SET_OP]) ? reg_wdata[6:0] : 7'h00;
  assign sw_clr = (wr_status && !reg_wdata[fls_pkg::BIT_SET_OP]) ? reg_wdata[6:0] : 7'h00;

  always_comb begin
    hw_set = {2'b00, ext_events};
    // Rising edges of the live flags: the unregistered compare result against the registered flag
    hw_set[fls_pkg::BIT_NEAR_FULL] = (free_cnt <= {1'b0, thr_eff}) && !near_full_flag;
    hw_set[fls_pkg::BIT_NEAR_EMPTY] = (fill_cnt <= {1'b0, thr_eff}) && !near_empty_flag;
    // Set terms applied after the clear so a colliding event survives
    next_status = (event_status_0 & ~sw_clr) | sw_set | hw_set;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      event_status_0 <= fls_pkg::STATUS_RESET;
    end else begin
      event_status_0 <= next_status;
    end
  end

  // ---------------------------------------------------------------
  // Read answer and address hold
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          fls_pkg::ADDR_THRESHOLD: reg_rdata <= threshold;
          fls_pkg::ADDR_FILL_COUNT: reg_rdata <= fill_cnt[7:0];
          fls_pkg::ADDR_BUFFER_PORT: reg_rdata <= pop ? mem_rd_data : 8'h00;
          fls_pkg::ADDR_EVENT_STATUS: reg_rdata <= {1'b0, event_status_0};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      addr_hold <= 1'b0;
    end else begin
      addr_hold <= (reg_rd || reg_wr) && hit(reg_addr, fls_pkg::ADDR_BUFFER_PORT);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_thr_write:
    assert property (reg_wr && reg_addr == 8'h03 |=> threshold == $past(reg_wdata))
    else $error("threshold not loaded by write");

  a_thr_width:
    assert property (!depth_select |-> thr_eff == {threshold_msb, threshold})
    else $error("large mode threshold lacks extension bit");

  a_thr_small:
    assert property (depth_select |-> thr_eff[8] == 1'b0)
    else $error("small mode threshold uses extension bit");

  a_empty_flag:
    assert property (fill_cnt == '0 && !flush |=> near_empty_flag)
    else $error("near-empty flag low on empty buffer");

  a_full_flag:
    assert property (fill_cnt == depth_eff && !flush |=> near_full_flag)
    else $error("near-full flag low on full buffer");

  a_depth_sel:
    assert property (depth_eff == (depth_select ? 10'h0ff : 10'h200))
    else $error("wrong depth for select");

  a_count_read:
    assert property (reg_rd && reg_addr == 8'h04 |=> reg_rvalid && reg_rdata == $past(fill_cnt[7:0]))
    else $error("fill count read wrong");

  a_count_msbs:
    assert property (##1 fill_count_msbs == ($past(depth_select) ? 2'b00 : $past(fill_cnt[9:8])))
    else $error("count extension bits wrong");

  a_count_large:
    assert property (!depth_select && fill_cnt == 10'h200 && !flush && !pop |=> fill_count_msbs == 2'b10)
    else $error("count 512 not represented");

  a_push_count:
    assert property (reg_wr && reg_addr == 8'h05 && fill_cnt < depth_eff && !flush
                     |=> fill_cnt == $past(fill_cnt) + 10'h001)
    else $error("count not incremented on push");

  a_pop_count:
    assert property (reg_rd && reg_addr == 8'h05 && fill_cnt != '0 && !flush
                     |=> fill_cnt == $past(fill_cnt) - 10'h001)
    else $error("count not decremented on pop");

  a_data_return:
    assert property (fill_cnt == '0 && !flush && reg_wr && reg_addr == 8'h05 ##1
                     !flush && !reg_wr && !reg_rd ##1
                     !flush && reg_rd && reg_addr == 8'h05 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("popped byte differs from pushed byte");

  a_addr_hold:
    assert property ((reg_rd || reg_wr) |=> addr_hold == ($past(reg_addr) == 8'h05))
    else $error("address hold wrong");

  a_status_clear:
    assert property (wr_status && reg_wdata == 8'h10 && !ext_events[4] |=> !event_status_0[4])
    else $error("status bit not cleared");

  a_status_keep:
    assert property (wr_status && !reg_wdata[1] && !ext_events[1]
                     |=> event_status_0[1] == $past(event_status_0[1]))
    else $error("unwritten status bit disturbed");

  a_status_all:
    assert property (wr_status && reg_wdata == 8'hff |=> event_status_0 == 7'h7f)
    else $error("FFh did not set all bits");

  a_nf_latch:
    assert property ($rose(near_full_flag) |-> ##[0:1] event_status_0[6])
    else $error("near-full event not latched");

  a_nf_hold:
    assert property (event_status_0[6] && !(wr_status && !reg_wdata[7] && reg_wdata[6])
                     |=> event_status_0[6])
    else $error("near-full event lost without clear");

  a_ne_latch:
    assert property ($rose(near_empty_flag) |-> ##[0:1] event_status_0[5])
    else $error("near-empty event not latched");

  a_set_wins:
    assert property (ext_events[0] && wr_status && reg_wdata == 8'h7f |=> event_status_0[0])
    else $error("event lost against clear");

  a_status_set:
    assert property (wr_status && reg_wdata[7] && reg_wdata[0] |=> event_status_0[0])
    else $error("status bit not set by write");

  a_clear_all:
    assert property (wr_status && reg_wdata == 8'h7f && hw_set == 7'h00
                     |=> event_status_0 == 7'h00)
    else $error("7Fh did not clear all bits");

  a_ne_hold:
    assert property (event_status_0[5] && !(wr_status && !reg_wdata[7] && reg_wdata[5])
                     |=> event_status_0[5])
    else $error("near-empty event lost without clear");

  a_pop_empty:
    assert property (reg_rd && !reg_wr && reg_addr == 8'h05 && fill_cnt == '0 && !flush
                     |=> fill_cnt == '0 && reg_rdata == 8'h00)
    else $error("read of empty buffer not refused");

  a_count_hold:
    assert property (!reg_wr && !reg_rd && !flush |=> $stable(fill_cnt))
    else $error("count moved without data port access");

  a_flush_empty:
    assert property (flush |=> fill_cnt == '0)
    else $error("flush left bytes counted");

  // Main scenarios the bench is expected to reach
  c_fill_full: cover property (fill_cnt == depth_eff);
  c_clear_all: cover property (wr_status && reg_wdata == 8'h7f);
  c_nf_event: cover property ($rose(event_status_0[6]));
  c_large_top: cover property (!depth_select && fill_count_msbs == 2'b10);
  c_set_collide: cover property (wr_status && !reg_wdata[7] && reg_wdata[0] && ext_events[0]);
endmodule // fls_top
`default_nettype wire

// >>> verification/fls_host_model.sv
/*
  Host register master for the fill-level block.
  Assumes one-cycle strobes and a read answer one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module fls_host_model (
  // Clock
  input wire logic mclk,
  // Register bus
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic addr_hold
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_wdata = 8'h00;
  end
  // Released lines get the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic hold);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
    hold = addr_hold;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v,
                    output logic hold);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
    hold = addr_hold;
  endtask
  // Operation bit and mask go in one byte
  task automatic set_status(input logic op, input logic [6:0] mask);
    logic h;
    wr(fls_pkg::ADDR_EVENT_STATUS, {op, mask}, h);
  endtask
endmodule // fls_host_model
`default_nettype wire

// >>> verification/fls_top_tb.sv
/*
  Self-checking bench for fls_top with a host model on the register bus.
  Assumes the package constants and the hand-over timing of the design.
*/
`timescale 1ns/1ps
`default_nettype none
module fls_top_tb;
  logic mclk, reset, reg_wr, reg_rd, reg_rvalid, addr_hold;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic depth_select, threshold_msb, flush, near_full_flag, near_empty_flag;
  logic [1:0] fill_count_msbs;
  logic [4:0] ext_events;
  logic [6:0] event_status_0;
  int err_total, num_checks;
  logic h;
  fls_top u_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .addr_hold(addr_hold), .depth_select(depth_select),
    .threshold_msb(threshold_msb), .flush(flush), .fill_count_msbs(fill_count_msbs),
    .near_full_flag(near_full_flag), .near_empty_flag(near_empty_flag),
    .ext_events(ext_events), .event_status_0(event_status_0));
  fls_host_model u_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .addr_hold(addr_hold));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check_val(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, output logic hold);
    logic [7:0] d;
    logic v;
    u_host.rd(a, d, v, hold);
    check_val({9'h000, v}, 10'h001);
    check_val({2'h0, d}, {2'h0, exp});
  endtask
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      u_host.wr(fls_pkg::ADDR_BUFFER_PORT, i[7:0], h);
    end
  endtask
  task automatic pop(input int n);
    logic [7:0] d;
    logic v;
    for (int i = 0; i < n; i++) begin
      u_host.rd(fls_pkg::ADDR_BUFFER_PORT, d, v, h);
    end
  endtask
  // Flags trail the count by one cycle
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic pulse_flush();
    @(posedge mclk);
    flush <= 1'h1;
    @(posedge mclk);
    flush <= 1'h0;
    settle();
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check_val({8'h00, fill_count_msbs}, 10'h000);
    check_val({8'h00, near_empty_flag, near_full_flag}, 10'h002);
    rd_chk(fls_pkg::ADDR_FILL_COUNT, 8'h00, h);
    rd_chk(fls_pkg::ADDR_EVENT_STATUS, 8'h00, h);
    rd_chk(8'h07, 8'h00, h);
    rd_chk(fls_pkg::ADDR_BUFFER_PORT, 8'h00, h);
    u_host.wr(fls_pkg::ADDR_THRESHOLD, 8'h5a, h);
    rd_chk(fls_pkg::ADDR_THRESHOLD, 8'h5a, h);
    u_host.wr(fls_pkg::ADDR_FILL_COUNT, 8'h33, h);
    rd_chk(fls_pkg::ADDR_FILL_COUNT, 8'h00, h);
    $display("t_reset done");
  endtask
  task automatic t_push_pop();
    u_host.wr(fls_pkg::ADDR_BUFFER_PORT, 8'ha1, h);
    check_val({9'h000, h}, 10'h001);
    u_host.wr(fls_pkg::ADDR_BUFFER_PORT, 8'hb2, h);
    rd_chk(fls_pkg::ADDR_FILL_COUNT, 8'h02, h);
    check_val({9'h000, h}, 10'h000);
    rd_chk(fls_pkg::ADDR_BUFFER_PORT, 8'ha1, h);
    check_val({9'h000, h}, 10'h001);
    rd_chk(fls_pkg::ADDR_BUFFER_PORT, 8'hb2, h);
    rd_chk(fls_pkg::ADDR_FILL_COUNT, 8'h00, h);
    u_host.wr(fls_pkg::ADDR_BUFFER_PORT, 8'hc3, h);
    rd_chk(fls_pkg::ADDR_BUFFER_PORT, 8'hc3, h);
    $display("t_push_pop done");
  endtask
  task automatic t_levels();
    u_host.wr(fls_pkg::ADDR_THRESHOLD, 8'h02, h);
    u_host.set_status(1'h0, 7'h7f);
    push(3);
    settle();
    check_val({9'h000, near_empty_flag}, 10'h000);
    pop(1);
    settle();
    check_val({8'h00, near_empty_flag, event_status_0[5]}, 10'h003);
    push(250);
    settle();
    check_val({9'h000, near_full_flag}, 10'h000);
    push(1);
    settle();
    check_val({8'h00, near_full_flag, event_status_0[6]}, 10'h003);
    pop(1);
    settle();
    check_val({8'h00, near_full_flag, event_status_0[6]}, 10'h001);
    push(4);
    rd_chk(fls_pkg::ADDR_FILL_COUNT, 8'hff, h);
    check_val({8'h00, fill_count_msbs}, 10'h000);
    pulse_flush();
    $display("t_levels done");
  endtask
  task automatic t_large();
    @(posedge mclk);
    depth_select <= 1'h0;
    threshold_msb <= 1'h1;
    u_host.wr(fls_pkg::ADDR_THRESHOLD, 8'h00, h);
    push(260);
    settle();
    check_val({8'h00, fill_count_msbs}, 10'h001);
    rd_chk(fls_pkg::ADDR_FILL_COUNT, 8'h04, h);
    check_val({8'h00, near_empty_flag, near_full_flag}, 10'h001);
    u_host.wr(fls_pkg::ADDR_THRESHOLD, 8'h04, h);
    settle();
    check_val({9'h000, near_empty_flag}, 10'h001);
    push(253);
    settle();
    check_val({7'h00, fill_count_msbs, near_full_flag}, 10'h005);
    rd_chk(fls_pkg::ADDR_FILL_COUNT, 8'h00, h);
    @(posedge mclk);
    depth_select <= 1'h1;
    settle();
    check_val({7'h00, fill_count_msbs, near_empty_flag}, 10'h000);
    pulse_flush();
    @(posedge mclk);
    depth_select <= 1'h0;
    threshold_msb <= 1'h0;
    $display("t_large done");
  endtask
  task automatic t_status();
    u_host.set_status(1'h0, 7'h7f);
    u_host.set_status(1'h1, 7'h7f);
    rd_chk(fls_pkg::ADDR_EVENT_STATUS, 8'h7f, h);
    u_host.set_status(1'h0, 7'h10);
    check_val({3'h0, event_status_0}, 10'h06f);
    u_host.set_status(1'h0, 7'h7f);
    check_val({3'h0, event_status_0}, 10'h000);
    u_host.set_status(1'h1, 7'h21);
    u_host.set_status(1'h0, 7'h01);
    u_host.set_status(1'h1, 7'h00);
    check_val({3'h0, event_status_0}, 10'h020);
    fork
      u_host.set_status(1'h0, 7'h7f);
      begin
        @(posedge mclk);
        ext_events <= 5'h01;
        @(posedge mclk);
        ext_events <= 5'h00;
      end
    join
    check_val({3'h0, event_status_0}, 10'h001);
    $display("t_status done");
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    err_total = 0;
    num_checks = 0;
    reset = 1'h1;
    depth_select = 1'h1;
    threshold_msb = 1'h0;
    flush = 1'h0;
    ext_events = 5'h00;
    repeat (8) @(posedge mclk);
    reset <= 1'h0;
    @(posedge mclk);
    #1;
    t_reset();
    t_push_pop();
    t_levels();
    t_large();
    t_status();
    tally_and_finish();
  end
endmodule // fls_top_tb
`default_nettype wire
